// ### include/lsad_defs.vh
`ifndef LSAD_DEFS_VH
`define LSAD_DEFS_VH

// Configuration offsets of the seven segment attribute registers and the fixed hole control register
`define LSAD_OFS_SYSBIOS      8'h59
`define LSAD_OFS_ADDON_C0     8'h5A
`define LSAD_OFS_ADDON_C8     8'h5B
`define LSAD_OFS_ADDON_D0     8'h5C
`define LSAD_OFS_ADDON_D8     8'h5D
`define LSAD_OFS_EXT_E0       8'h5E
`define LSAD_OFS_EXT_E8       8'h5F
`define LSAD_OFS_HOLE         8'h68
`define LSAD_NUM_ATTR         7

// Reset values
`define LSAD_ATTR_RST         8'h00
`define LSAD_HOLE_RST         2'h0

// Writable bit masks: reserved bits and the unused low nibble stay zero
`define LSAD_MASK_SYSBIOS     8'h30
`define LSAD_MASK_ADDON       8'h33

// Field layout inside one 4-bit region field
`define LSAD_FLD_RD           0
`define LSAD_FLD_WR           1
`define LSAD_FLD_W            4
`define LSAD_SYSBIOS_FLD_POS  6'd4
`define LSAD_ADDON_FLD_BASE   6'd8

// Hole select field of the fixed hole control register
`define LSAD_HOLE_HI          7
`define LSAD_HOLE_LO          6
`define LSAD_HOLE_NONE        2'b00
`define LSAD_HOLE_DOS         2'b01
`define LSAD_HOLE_15M         2'b10

// Address region codes, upper address bits
`define LSAD_ADDR_W           32
`define LSAD_UPPER_15M        12'h00F
`define LSAD_DOS_HI_A19_17    3'b100
`define LSAD_VIDEO_A19_17     3'b101
`define LSAD_ADDON_SEG0       6'h30
`define LSAD_SYSBIOS_A19_16   4'hF

`endif

// ### logic/lsad_attr_mem.v
`timescale 1ns/100ps
`default_nettype none
`include "lsad_defs.vh"

// Seven 8-bit attribute registers; all of them are also presented flat so the
// routing decode can see every field at once, while config reads are registered.
module lsad_attr_mem (
	input  wire        core_clk,
	input  wire        rstn,
	input  wire        wr_en,
	input  wire [2:0]  wr_idx,
	input  wire [7:0]  wr_data,
	input  wire [2:0]  rd_idx,
	output reg  [7:0]  rd_data_reg,
	output wire [55:0] attr_flat
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `LSAD_NUM_ATTR; g = g + 1) begin : g_attr
			reg  [7:0] attr_reg;
			wire [7:0] mask = (g == 0) ? `LSAD_MASK_SYSBIOS : `LSAD_MASK_ADDON;
			// Reserved bits are never stored, so they read zero and never steer routing
			always @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					attr_reg <= `LSAD_ATTR_RST; // R10
				end else if (wr_en && (wr_idx == g)) begin
					attr_reg <= wr_data & mask; // R17 R11
				end
			end
			assign attr_flat[g*8 +: 8] = attr_reg;
		end
	endgenerate

	// ------------------------------------------------------------
	// Registered read port
	// ------------------------------------------------------------
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data_reg <= 8'h00;
		end else if (rd_idx < `LSAD_NUM_ATTR) begin
			rd_data_reg <= attr_flat[rd_idx*8 +: 8]; // R10
		end else begin
			rd_data_reg <= 8'h00;
		end
	end

endmodule // lsad_attr_mem
`default_nettype wire

// ### logic/lsad_field_sel.v
`timescale 1ns/100ps
`default_nettype none
`include "lsad_defs.vh"

// Picks the 4-bit attribute field that governs an address in 0C0000h-0FFFFFh.
module lsad_field_sel (
	input  wire [19:14] addr_hi,
	input  wire [55:0]  attr_flat,
	output wire         rd_to_dram,
	output wire         wr_to_dram
);

	// ------------------------------------------------------------
	// Field position from address bits 19:14
	// ------------------------------------------------------------
	function [5:0] fld_pos;
		input [5:0] a;
		reg   [5:0] seg;
		begin
			seg = a - `LSAD_ADDON_SEG0;
			if (a[5:2] == `LSAD_SYSBIOS_A19_16)
				fld_pos = `LSAD_SYSBIOS_FLD_POS; // R11
			else
				fld_pos = `LSAD_ADDON_FLD_BASE + {seg[3:0], 2'b00}; // R12 R18
		end
	endfunction

	wire [5:0] pos = fld_pos(addr_hi);
	wire [3:0] fld = attr_flat[pos +: `LSAD_FLD_W];

	assign rd_to_dram = fld[`LSAD_FLD_RD]; // R3
	assign wr_to_dram = fld[`LSAD_FLD_WR]; // R3

endmodule // lsad_field_sel
`default_nettype wire

// ### logic/lsad_decoder.v
// How it works
// (R1) Thirteen legacy segments, seven attribute registers
// (R2) Same attributes govern host and initiator accesses
// (R3) Each nibble: read bit, write bit, two reserved
// (R4) Read bit set: reads to DRAM, else PCI
// (R5) Write bit set: writes to DRAM, else PCI
// (R6) Both clear: all to PCI, never claim
// (R7) Read only: writes to PCI, claim reads
// (R8) Write only: reads to PCI, claim writes
// (R9) Both set: DRAM, claim reads and writes
// (R10) Registers reset zero, all read and write
// (R11) First register high nibble: F0000h segment
// (R12) Twelve 16 KB segments ascending, low nibble first
// (R13) Lowest 512 KB always main memory
// (R14) 80000h-9FFFFh DRAM unless hole selected
// (R15) Shadowing: write-only, copy, then read-only
// (R16) Hole 01 passes host, ignores PCI
// (R17) Reserved bits read zero, writes ignored
// (R18) Address bits 19:14 pick the field
`timescale 1ns/100ps
`default_nettype none
`include "lsad_defs.vh"

module lsad_decoder (
	input  wire        core_clk,
	input  wire        rstn,
	// Configuration access port
	input  wire        cfg_valid,
	input  wire        cfg_write,
	input  wire [7:0]  cfg_addr,
	input  wire [7:0]  cfg_wdata,
	output reg  [7:0]  cfg_rdata_reg,
	output reg         cfg_done_reg,
	// Host processor requests
	input  wire        host_valid,
	input  wire        host_write,
	input  wire [31:0] host_addr,
	output reg         host_done_reg,
	output reg         host_to_dram_reg,
	output reg         host_to_pci_reg,
	// PCI or graphics-port initiator requests
	input  wire        init_valid,
	input  wire        init_write,
	input  wire [31:0] init_addr,
	output reg         init_done_reg,
	output reg         init_claim_reg,
	output reg         init_legacy_reg
);

	// ------------------------------------------------------------
	// Region codes
	// ------------------------------------------------------------
	localparam [2:0] RG_DOS_LO  = 3'd0;
	localparam [2:0] RG_DOS_HI  = 3'd1;
	localparam [2:0] RG_VIDEO   = 3'd2;
	localparam [2:0] RG_SEGMENT = 3'd3;
	localparam [2:0] RG_HOLE15  = 3'd4;
	localparam [2:0] RG_HIGH    = 3'd5;

	// ------------------------------------------------------------
	// Shared decode functions
	// ------------------------------------------------------------
	// Classify an address into the region that decides its route
	function [2:0] region_of;
		input [31:0] a;
		begin
			if (a[31:20] == `LSAD_UPPER_15M)
				region_of = RG_HOLE15;
			else if (a[31:20] != 12'h000)
				region_of = RG_HIGH;
			else if (!a[19])
				region_of = RG_DOS_LO;
			else if (a[19:17] == `LSAD_DOS_HI_A19_17)
				region_of = RG_DOS_HI;
			else if (a[19:17] == `LSAD_VIDEO_A19_17)
				region_of = RG_VIDEO;
			else
				region_of = RG_SEGMENT;
		end
	endfunction

	// Decide whether main memory owns an access
	function dram_owns;
		input [2:0] rg;
		input       wr;
		input       rd_bit;
		input       wr_bit;
		input [1:0] hole;
		begin
			case (rg)
				RG_DOS_LO:  dram_owns = 1'b1; // R13
				RG_DOS_HI:  dram_owns = (hole != `LSAD_HOLE_DOS); // R14 R16
				RG_VIDEO:   dram_owns = 1'b0;
				RG_SEGMENT: dram_owns = wr ? wr_bit : rd_bit; // R4 R5 R6 R7 R8 R9
				RG_HOLE15:  dram_owns = (hole != `LSAD_HOLE_15M); // R16
				RG_HIGH:    dram_owns = 1'b1;
				default:    dram_owns = 1'b1;
			endcase
		end
	endfunction

	// Map a config offset onto an attribute register index, 7 when no hit
	function [2:0] attr_index;
		input [7:0] ofs;
		begin
			if (ofs >= `LSAD_OFS_SYSBIOS && ofs <= `LSAD_OFS_EXT_E8)
				attr_index = ofs[2:0] - 3'd1; // R1 R12
			else
				attr_index = 3'd7;
		end
	endfunction

	// ------------------------------------------------------------
	// Configuration decode
	// ------------------------------------------------------------
	wire [2:0]  cfg_idx      = attr_index(cfg_addr);
	wire        cfg_attr_hit = (cfg_idx != 3'd7);
	wire        cfg_hole_hit = (cfg_addr == `LSAD_OFS_HOLE);
	wire        attr_wr_en   = cfg_valid && cfg_write && cfg_attr_hit;
	wire [7:0]  attr_rd_data;
	wire [55:0] attr_flat;

	lsad_attr_mem u_attr_mem (
		.core_clk    (core_clk),
		.rstn        (rstn),
		.wr_en       (attr_wr_en),
		.wr_idx      (cfg_idx),
		.wr_data     (cfg_wdata),
		.rd_idx      (cfg_idx),
		.rd_data_reg (attr_rd_data),
		.attr_flat   (attr_flat)
	);

	// ------------------------------------------------------------
	// Fixed hole control
	// ------------------------------------------------------------
	reg [1:0] hole_sel_reg;

	// Only the hole select field is kept; the rest of the byte reads zero
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hole_sel_reg <= `LSAD_HOLE_RST;
		end else if (cfg_valid && cfg_write && cfg_hole_hit) begin
			hole_sel_reg <= cfg_wdata[`LSAD_HOLE_HI:`LSAD_HOLE_LO]; // R14
		end
	end

	// ------------------------------------------------------------
	// Configuration read pipeline
	// ------------------------------------------------------------
	// Two stages: the attribute store registers its own read data, so the
	// hole byte and the hit flags are delayed one cycle to line up with it.
	reg       cfg_stage_reg;
	reg       cfg_src_attr_reg;
	reg       cfg_src_hole_reg;
	reg [1:0] cfg_hole_snap_reg;

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_stage_reg     <= 1'b0;
			cfg_src_attr_reg  <= 1'b0;
			cfg_src_hole_reg  <= 1'b0;
			cfg_hole_snap_reg <= 2'b00;
		end else begin
			cfg_stage_reg     <= cfg_valid;
			cfg_src_attr_reg  <= cfg_valid && !cfg_write && cfg_attr_hit;
			cfg_src_hole_reg  <= cfg_valid && !cfg_write && cfg_hole_hit;
			cfg_hole_snap_reg <= hole_sel_reg;
		end
	end

	// Unmapped offsets and writes return zero data
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_done_reg  <= 1'b0;
			cfg_rdata_reg <= 8'h00;
		end else begin
			cfg_done_reg <= cfg_stage_reg;
			if (cfg_src_attr_reg)
				cfg_rdata_reg <= attr_rd_data; // R10 R17
			else if (cfg_src_hole_reg)
				cfg_rdata_reg <= {cfg_hole_snap_reg, 6'b00_0000};
			else
				cfg_rdata_reg <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Host access routing
	// ------------------------------------------------------------
	wire       host_rd_bit;
	wire       host_wr_bit;
	wire [2:0] host_region = region_of(host_addr);

	lsad_field_sel u_host_field (
		.addr_hi    (host_addr[19:14]),
		.attr_flat  (attr_flat),
		.rd_to_dram (host_rd_bit),
		.wr_to_dram (host_wr_bit)
	);

	wire host_dram = dram_owns(host_region, host_write, host_rd_bit,
		host_wr_bit, hole_sel_reg); // R2

	// Decision held until the next host request
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			host_done_reg    <= 1'b0;
			host_to_dram_reg <= 1'b0;
			host_to_pci_reg  <= 1'b0;
		end else begin
			host_done_reg <= host_valid;
			if (host_valid) begin
				host_to_dram_reg <= host_dram; // R4 R5
				host_to_pci_reg  <= !host_dram; // R6 R7 R8
			end
		end
	end

	// ------------------------------------------------------------
	// Initiator target claim
	// ------------------------------------------------------------
	// Initiator traffic uses the same fields as the host; a hole or a
	// cleared attribute means the bridge stays silent as a target.
	wire       init_rd_bit;
	wire       init_wr_bit;
	wire [2:0] init_region = region_of(init_addr);

	lsad_field_sel u_init_field (
		.addr_hi    (init_addr[19:14]),
		.attr_flat  (attr_flat),
		.rd_to_dram (init_rd_bit),
		.wr_to_dram (init_wr_bit)
	);

	wire init_dram   = dram_owns(init_region, init_write, init_rd_bit,
		init_wr_bit, hole_sel_reg); // R2 R16
	wire init_legacy = (init_region == RG_SEGMENT) || (init_region == RG_DOS_HI);

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			init_done_reg   <= 1'b0;
			init_claim_reg  <= 1'b0;
			init_legacy_reg <= 1'b0;
		end else begin
			init_done_reg <= init_valid;
			if (init_valid) begin
				init_claim_reg  <= init_dram; // R6 R7 R8 R9
				init_legacy_reg <= init_legacy;
			end
		end
	end

endmodule // lsad_decoder
`default_nettype wire

// ### verification/lsad_chk_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Routing and config checks
// ------------------------------
module lsad_chk (
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic        cfg_valid,
	input wire logic        cfg_write,
	input wire logic [7:0]  cfg_addr,
	input wire logic [7:0]  cfg_rdata_reg,
	input wire logic        cfg_done_reg,
	input wire logic        host_valid,
	input wire logic [31:0] host_addr,
	input wire logic        host_done_reg,
	input wire logic        host_to_dram_reg,
	input wire logic        host_to_pci_reg,
	input wire logic        init_valid,
	input wire logic [31:0] init_addr,
	input wire logic        init_done_reg,
	input wire logic        init_claim_reg,
	input wire logic        init_legacy_reg
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Config answer lands two edges after the request is taken
	sequence ans_s;
		##2 cfg_done_reg;
	endsequence
	sequence rd_s(logic [7:0] m);
		##2 ((cfg_rdata_reg & m) == 8'h00);
	endsequence
	cfg_done_a: assert property (cfg_valid |-> ans_s)
		else $error("config access not answered");
	rd_bios_a: assert property (cfg_valid && cfg_addr == 8'h59 |-> rd_s(8'hCF))
		else $error("bios register unused bits set");
	rd_rsvd_a: assert property (cfg_valid && cfg_addr > 8'h59 && cfg_addr < 8'h60 |-> rd_s(8'hCC))
		else $error("reserved attribute bits set");
	unmap_a: assert property (cfg_valid && (cfg_addr < 8'h59 || cfg_addr > 8'h5F
		&& cfg_addr != 8'h68) |-> rd_s(8'hFF))
		else $error("unmapped offset read nonzero");
	host_done_a: assert property (host_valid |=> host_done_reg)
		else $error("host request not answered");
	init_done_a: assert property (init_valid |=> init_done_reg)
		else $error("initiator request not answered");
	route_one_a: assert property (host_done_reg |-> host_to_dram_reg != host_to_pci_reg)
		else $error("host route not exclusive");
	hold_a: assert property (!host_valid |=> $stable(host_to_dram_reg))
		else $error("host route changed without request");
	dos_low_a: assert property (host_valid && host_addr < 32'h0008_0000 |=> host_to_dram_reg)
		else $error("low dos area left dram");
	dos_init_a: assert property (init_valid && init_addr < 32'h0008_0000 |=> init_claim_reg)
		else $error("low dos area not claimed");
	legacy_a: assert property (init_valid && init_addr[31:18] == 14'h0003 |=> init_legacy_reg)
		else $error("legacy segment not flagged");
endmodule // lsad_chk

bind lsad_decoder lsad_chk chk_u (.*);
`default_nettype wire

// ### verification/lsad_req_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Host and initiator requester
// ------------------------------
module lsad_req_model (
	input  wire logic        core_clk,
	input  wire logic        host_done_reg,
	input  wire logic        host_to_dram_reg,
	input  wire logic        host_to_pci_reg,
	input  wire logic        init_done_reg,
	input  wire logic        init_claim_reg,
	output var  logic        host_valid,
	output var  logic        host_write,
	output var  logic [31:0] host_addr,
	output var  logic        init_valid,
	output var  logic        init_write,
	output var  logic [31:0] init_addr
);
	// Idle bus at time zero
	initial begin
		host_valid = 1'b0;
		host_write = 1'b0;
		host_addr  = 32'h0000_0000;
		init_valid = 1'b0;
		init_write = 1'b0;
		init_addr  = 32'h0000_0000;
	end
	// One-cycle request; released lines flip so stale values never look valid
	task access(input logic ini, input logic wr, input logic [31:0] a, output logic [1:0] r);
		int n;
		@(posedge core_clk);
		#1;
		host_valid = !ini;
		host_write = wr;
		host_addr  = a;
		init_valid = ini;
		init_write = wr;
		init_addr  = a;
		@(posedge core_clk);
		#1;
		host_valid = 1'b0;
		init_valid = 1'b0;
		host_addr  = ~a;
		init_addr  = ~a;
		for (n = 0; n < 4 && (ini ? init_done_reg : host_done_reg) !== 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		r = ini ? {init_claim_reg, ~init_claim_reg} : {host_to_dram_reg, host_to_pci_reg};
		if ((ini ? init_done_reg : host_done_reg) !== 1'b1)
			r = 2'bxx;
	endtask
endmodule // lsad_req_model
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Decoder testbench
// ------------------------------
module testbench;
	logic        core_clk, rstn, cfg_valid, cfg_write, cfg_done_reg;
	logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata_reg;
	logic        host_valid, host_write, host_done_reg, host_to_dram_reg, host_to_pci_reg;
	logic        init_valid, init_write, init_done_reg, init_claim_reg, init_legacy_reg;
	logic [31:0] host_addr, init_addr;
	int          fail_count = 0;
	int          cmp_count = 0;

	lsad_decoder dut_u (.core_clk(core_clk), .rstn(rstn), .cfg_valid(cfg_valid),
		.cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_rdata_reg(cfg_rdata_reg), .cfg_done_reg(cfg_done_reg),
		.host_valid(host_valid), .host_write(host_write), .host_addr(host_addr),
		.host_done_reg(host_done_reg), .host_to_dram_reg(host_to_dram_reg),
		.host_to_pci_reg(host_to_pci_reg), .init_valid(init_valid),
		.init_write(init_write), .init_addr(init_addr), .init_done_reg(init_done_reg),
		.init_claim_reg(init_claim_reg), .init_legacy_reg(init_legacy_reg));
	lsad_req_model req_u (.core_clk(core_clk), .host_done_reg(host_done_reg),
		.host_to_dram_reg(host_to_dram_reg), .host_to_pci_reg(host_to_pci_reg),
		.init_done_reg(init_done_reg), .init_claim_reg(init_claim_reg),
		.host_valid(host_valid), .host_write(host_write), .host_addr(host_addr),
		.init_valid(init_valid), .init_write(init_write), .init_addr(init_addr));

	// 200 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("Compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One-pulse config access; wait for the answer under a bound
	task cfg(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge core_clk);
		#1;
		cfg_valid = 1'b1;
		cfg_write = wr;
		cfg_addr  = a;
		cfg_wdata = d;
		@(posedge core_clk);
		#1;
		cfg_valid = 1'b0;
		cfg_addr  = ~a;
		cfg_wdata = ~d;
		for (n = 0; n < 4 && cfg_done_reg !== 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		q = (cfg_done_reg === 1'b1) ? cfg_rdata_reg : 8'hxx;
	endtask
	// Whole run is about a thousand cycles; this bound is generous
	initial begin
		#60000;
		fail_count++;
		finish_test;
	end
	initial begin
		logic [7:0]  q, o;
		logic [1:0]  r;
		logic [31:0] a;
		int          n, c, k;
		cfg_valid = 1'b0;
		cfg_write = 1'b0;
		cfg_addr  = 8'h00;
		cfg_wdata = 8'h00;
		rstn = 1'b0;
		repeat (12) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		// Reset values, then reserved bits dropped on an all-ones write
		for (k = 0; k < 7; k++) begin
			cfg(1'b0, 8'h59 + 8'(k), 8'h00, q);
			check(q, 8'h00);
			cfg(1'b1, 8'h59 + 8'(k), 8'hFF, q);
			cfg(1'b0, 8'h59 + 8'(k), 8'h00, q);
			check(q, k ? 8'h33 : 8'h30);
			cfg(1'b1, 8'h59 + 8'(k), 8'h00, q);
		end
		cfg(1'b1, 8'h60, 8'hFF, q);
		cfg(1'b0, 8'h60, 8'h00, q);
		check(q, 8'h00);
		// Every segment, every code, both directions, both initiators
		for (n = 0; n < 13; n++) begin
			for (c = 0; c < 4; c++) begin
				o = (n == 12) ? 8'h59 : 8'h5A + 8'(n / 2);
				cfg(1'b1, o, (8'(c) | 8'h0C) << ((n == 12 || n % 2) ? 4 : 0), q);
				a = (n == 12) ? 32'h000F_FFFC : 32'h000C_3FFC + 32'(n) * 32'h0000_4000;
				for (k = 0; k < 4; k++) begin
					req_u.access(k[1], k[0], a, r);
					check({6'h00, r}, {6'h00, c[k[0]], !c[k[0]]});
				end
				req_u.access(1'b0, 1'b0, (n == 12) ? 32'h000C_0000 : a + 32'h0000_4000, r);
				check({6'h00, r}, 8'h01);
				cfg(1'b1, o, 8'h00, q);
			end
		end
		// Low DOS area fixed, upper part moves with the hole select
		for (k = 0; k < 4; k++) begin
			req_u.access(k[1], k[0], 32'h0008_0000, r);
			check({6'h00, r}, 8'h02);
		end
		cfg(1'b1, 8'h68, 8'h40, q);
		for (k = 0; k < 4; k++) begin
			req_u.access(k[1], k[0], 32'h0009_FFFC, r);
			check({6'h00, r}, 8'h01);
			req_u.access(k[1], k[0], 32'h0007_FFFC, r);
			check({6'h00, r}, 8'h02);
		end
		// Hole select keeps only its two bits; code 11 is reserved and opens no hole
		cfg(1'b1, 8'h68, 8'hFF, q);
		cfg(1'b0, 8'h68, 8'h00, q);
		check(q, 8'hC0);
		for (k = 0; k < 4; k++) begin
			req_u.access(k[1], k[0], 32'h0009_FFFC, r);
			check({6'h00, r}, 8'h02);
			req_u.access(k[1], k[0], 32'h00F0_0000, r);
			check({6'h00, r}, 8'h02);
		end
		// Upper hole: only 15-16 MB leaves memory, the DOS range comes back
		cfg(1'b1, 8'h68, 8'h80, q);
		for (k = 0; k < 4; k++) begin
			req_u.access(k[1], k[0], 32'h00FF_FFFC, r);
			check({6'h00, r}, 8'h01);
			req_u.access(k[1], k[0], 32'h0200_0000, r);
			check({6'h00, r}, 8'h02);
			req_u.access(k[1], k[0], 32'h0009_FFFC, r);
			check({6'h00, r}, 8'h02);
		end
		// Video window is no segment and never claimed; legacy flag follows the range
		req_u.access(1'b1, 1'b0, 32'h000A_0000, r);
		check({6'h00, r}, 8'h01);
		check({7'h00, init_legacy_reg}, 8'h00);
		req_u.access(1'b1, 1'b1, 32'h0008_0000, r);
		check({7'h00, init_legacy_reg}, 8'h01);
		req_u.access(1'b1, 1'b0, 32'h000D_4000, r);
		check({6'h00, r}, 8'h01);
		check({7'h00, init_legacy_reg}, 8'h01);
		// Firmware shadowing: write-only while copying, then read-only
		cfg(1'b1, 8'h59, 8'h20, q);
		req_u.access(1'b0, 1'b0, 32'h000F_1230, r);
		check({6'h00, r}, 8'h01);
		req_u.access(1'b0, 1'b1, 32'h000F_1230, r);
		check({6'h00, r}, 8'h02);
		cfg(1'b1, 8'h59, 8'h10, q);
		req_u.access(1'b0, 1'b0, 32'h000F_1230, r);
		check({6'h00, r}, 8'h02);
		req_u.access(1'b0, 1'b1, 32'h000F_1230, r);
		check({6'h00, r}, 8'h01);
		finish_test;
	end
endmodule // testbench
`default_nettype wire
